// ==== src/iscc_top.sv ====
// Purpose: Decodes control commands and returns prioritised status codes.
// Assumes: Event inputs come from the link clock domain and are sampled on
//          its rising edges; cmd_valid comes from clk_sys logic.
// Notes:   One pending event is returned per command exchange.
`timescale 1ns/1ps
module iscc_top
  import iscc_pkg::*;
(
  input  wire logic       clk_sys,      // 50 MHz system clock.
  input  wire logic       srst,         // Synchronous reset, active high.
  input  wire logic       ce,           // Clock enable; low freezes all state.
  input  wire logic       link_clk,     // Link clock pin, sampled.
  input  wire logic       cmd_valid,    // Command byte strobe, one cycle.
  input  wire logic [7:0] cmd_byte,     // Command register byte.
  input  wire iscc_evt_s  evt,          // Event levels from line logic.
  input  wire logic [2:0] line_state,   // Activation state bits.
  output logic [7:0]      status_byte,  // Status register byte.
  output logic            status_valid, // Status ready pulse.
  output logic            irq,          // Interrupt level: status pending.
  output iscc_ctrl_s      ctrl          // Current control settings.
);
  logic        link_rise;
  iscc_evt_s   evt_m;
  iscc_evt_s   evt_s;
  iscc_evt_s   evt_p;
  logic [NUM_EVENTS-1:0] pend;
  logic [NUM_EVENTS-1:0] set_ev;
  logic [NUM_EVENTS-1:0] clr_ev;
  logic [3:0]  mf_one_hold;
  logic [3:0]  mf_two_hold;
  logic [2:0]  tick_cnt;
  logic [2:0]  state_s1;
  logic [2:0]  state_s2;
  logic [7:0]  next_status;
  logic [NUM_EVENTS-1:0] next_clr;

  iscc_link_sync u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .ce       (ce),
    .link_clk (link_clk),
    .rise     (link_rise)
  );

  // Event levels are outside the clock domain: two stages before use.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evt_m    <= '0;
      evt_s    <= '0;
      evt_p    <= '0;
      state_s1 <= '0;
      state_s2 <= '0;
    end else if (ce) begin
      evt_m    <= evt;
      evt_s    <= evt_m;
      state_s1 <= line_state;
      state_s2 <= state_s1;
      if (link_rise) begin
        evt_p <= evt_s;
      end
    end
  end

  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction

  function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] c);
    return cmd_valid && (b == c);
  endfunction

  // Command decode into control flags.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl.state_report  <= RST_STATE_REPORT;
      ctrl.extra_irq     <= RST_EXTRA_IRQ;
      ctrl.invert_first  <= RST_INVERT;
      ctrl.invert_second <= RST_INVERT;
      ctrl.message_irq   <= RST_MESSAGE_IRQ;
      ctrl.mf_one_irq    <= RST_MF_IRQ;
      ctrl.mf_two_irq    <= RST_MF_IRQ;
      ctrl.tick_every    <= RST_TICK;
      ctrl.tick_sixth    <= RST_TICK;
      ctrl.pin_sel       <= RST_PIN_SEL;
    end else if (ce) begin
      if (cmd_is(cmd_byte, CMD_STATE_REPORT_OFF)) ctrl.state_report <= 1'b0;
      if (cmd_is(cmd_byte, CMD_STATE_REPORT_ON))  ctrl.state_report <= 1'b1;
      if (cmd_is(cmd_byte, CMD_EXTRA_IRQ_ON))     ctrl.extra_irq <= 1'b1;
      if (cmd_is(cmd_byte, CMD_EXTRA_IRQ_OFF))    ctrl.extra_irq <= 1'b0;
      if (cmd_is(cmd_byte, CMD_INVERT_FIRST))     ctrl.invert_first <= 1'b1;
      if (cmd_is(cmd_byte, CMD_INVERT_SECOND))    ctrl.invert_second <= 1'b1;
      if (cmd_is(cmd_byte, CMD_NORMAL_POLARITY)) begin
        ctrl.invert_first  <= 1'b0;
        ctrl.invert_second <= 1'b0;
      end
      if (cmd_valid && cmd_byte[7:3] == CMD_PIN_REDEFINE_TOP) begin
        ctrl.pin_sel <= cmd_byte[2:0];
      end
      if (cmd_is(cmd_byte, CMD_MESSAGE_IRQ_ON))   ctrl.message_irq <= 1'b1;
      if (cmd_is(cmd_byte, CMD_MESSAGE_IRQ_OFF))  ctrl.message_irq <= 1'b0;
      if (cmd_is(cmd_byte, CMD_MF_ONE_IRQ_ON))    ctrl.mf_one_irq <= 1'b1;
      if (cmd_is(cmd_byte, CMD_MF_ONE_IRQ_OFF))   ctrl.mf_one_irq <= 1'b0;
      if (cmd_is(cmd_byte, CMD_MF_TWO_IRQ_ON))    ctrl.mf_two_irq <= 1'b1;
      if (cmd_is(cmd_byte, CMD_MF_TWO_IRQ_OFF))   ctrl.mf_two_irq <= 1'b0;
      if (cmd_is(cmd_byte, CMD_TICK_EVERY_ON))    ctrl.tick_every <= 1'b1;
      if (cmd_is(cmd_byte, CMD_TICK_EVERY_OFF))   ctrl.tick_every <= 1'b0;
      if (cmd_is(cmd_byte, CMD_TICK_SIXTH_ON))    ctrl.tick_sixth <= 1'b1;
      if (cmd_is(cmd_byte, CMD_TICK_SIXTH_OFF))   ctrl.tick_sixth <= 1'b0;
    end
  end

  // Boundary counter for the every-sixth tick.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_cnt <= '0;
    end else if (ce && link_rise && rose(evt_s.mf_boundary, evt_p.mf_boundary)) begin
      tick_cnt <= (tick_cnt == 3'(TICK_SIXTH_COUNT - 1)) ? 3'h0 : tick_cnt + 3'h1;
    end
  end

  // Event edges, gated by their enables.
  always_comb begin
    set_ev = '0;
    if (ce && link_rise) begin
      set_ev[EV_FAR]   = rose(evt_s.far_end_signal, evt_p.far_end_signal);
      set_ev[EV_PEND]  = rose(evt_s.activation_pending, evt_p.activation_pending);
      set_ev[EV_DONE]  = rose(evt_s.activation_done, evt_p.activation_done);
      set_ev[EV_ERR]   = rose(evt_s.frame_loss_error, evt_p.frame_loss_error);
      set_ev[EV_DEACT] = rose(evt_s.deactivated_flag, evt_p.deactivated_flag);
      set_ev[EV_SENT]  = ctrl.message_irq & rose(evt_s.message_sent, evt_p.message_sent);
      set_ev[EV_CONT]  = rose(evt_s.contention_lost, evt_p.contention_lost);
      set_ev[EV_MF1]   = ctrl.mf_one_irq & rose(evt_s.mf_rx_buf_one, evt_p.mf_rx_buf_one);
      set_ev[EV_MF2]   = ctrl.mf_two_irq & rose(evt_s.mf_rx_buf_two, evt_p.mf_rx_buf_two);
      set_ev[EV_TICK]  = rose(evt_s.mf_boundary, evt_p.mf_boundary)
                         & (ctrl.tick_every
                            | (ctrl.tick_sixth && tick_cnt == 3'(TICK_SIXTH_COUNT - 1)));
      set_ev[EV_RX_MULTIFRAME_ERROR]  = ctrl.extra_irq & rose(evt_s.rx_violation, evt_p.rx_violation);
      // A slip on both buffers in one edge gives a single combined report.
      set_ev[EV_SLBOTH] = ctrl.extra_irq & rose(evt_s.slip_tx, evt_p.slip_tx)
                          & rose(evt_s.slip_rx, evt_p.slip_rx);
      set_ev[EV_SLTX]  = ctrl.extra_irq & rose(evt_s.slip_tx, evt_p.slip_tx)
                         & ~set_ev[EV_SLBOTH];
      set_ev[EV_SLRX]  = ctrl.extra_irq & rose(evt_s.slip_rx, evt_p.slip_rx)
                         & ~set_ev[EV_SLBOTH];
    end
  end

  // Latch message bits with their buffer event.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mf_one_hold <= '0;
      mf_two_hold <= '0;
    end else if (ce) begin
      if (set_ev[EV_MF1]) mf_one_hold <= evt_s.mf_one_bits;
      if (set_ev[EV_MF2]) mf_two_hold <= evt_s.mf_two_bits;
    end
  end

  // Highest-priority pending event is answered on a command.
  always_comb begin
    next_clr = '0;
    if (ctrl.state_report) begin
      next_status = {1'b1, state_s2, 4'h0};
    end else begin
      next_status = ST_NO_CHANGE;
    end
    for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        next_clr = '0;
        next_clr[i] = 1'b1;
        case (iscc_ev_e'(i))
          EV_FAR:    next_status = ST_FAR_END_SIGNAL;
          EV_PEND:   next_status = ST_ACTIVATION_PENDING;
          EV_DONE:   next_status = ST_ACTIVATION_DONE;
          EV_ERR:    next_status = ST_FRAME_LOSS_ERROR;
          EV_DEACT:  next_status = ST_DEACTIVATED;
          EV_SENT:   next_status = ST_MESSAGE_SENT;
          EV_CONT:   next_status = ST_CONTENTION_LOST;
          EV_MF1:    next_status = {ST_MF_BUF_ONE_TOP, mf_one_hold};
          EV_MF2:    next_status = {ST_MF_BUF_TWO_TOP, mf_two_hold};
          EV_TICK:   next_status = ST_MF_TX_TICK;
          EV_RX_MULTIFRAME_ERROR:   next_status = ST_RX_MF_ERROR;
          EV_SLTX:   next_status = ST_SLIP_TX;
          EV_SLRX:   next_status = ST_SLIP_RX;
          EV_SLBOTH: next_status = ST_SLIP_BOTH;
          default:   next_status = ST_NO_CHANGE;
        endcase
      end
    end
  end

  assign clr_ev = (ce && cmd_valid) ? next_clr : '0;

  // Pending flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend <= '0;
    end else if (ce) begin
      pend <= (pend & ~clr_ev) | set_ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_byte  <= ST_NO_CHANGE;
      status_valid <= 1'b0;
      irq          <= 1'b0;
    end else if (ce) begin
      status_valid <= cmd_valid;
      if (cmd_valid) status_byte <= next_status;
      irq <= |((pend & ~clr_ev) | set_ev);
    end
  end

  // Control decode and answer format.
  chk_idle_no_irq: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && pend == '0 && set_ev == '0 && !ctrl.state_report) |=>
      (status_byte == ST_NO_CHANGE && !irq))
    else $error("idle answer not zero");

  chk_state_form: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && pend == '0 && ctrl.state_report) |=>
      (status_byte[STATE_FLAG_BIT] && status_byte[3:0] == 4'h0))
    else $error("state answer malformed");

  chk_cmd_report_off: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_is(cmd_byte, CMD_STATE_REPORT_OFF)) |=> !ctrl.state_report)
    else $error("report not off");

  chk_extra_on: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_is(cmd_byte, CMD_EXTRA_IRQ_ON)) |=> ctrl.extra_irq)
    else $error("extra interrupts not enabled");

  chk_extra_off: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_is(cmd_byte, CMD_EXTRA_IRQ_OFF)) |=> !ctrl.extra_irq)
    else $error("extra interrupts not disabled");

  chk_extra_gate: assert property (@(posedge clk_sys) disable iff (srst)
    !ctrl.extra_irq |-> !(set_ev[EV_RX_MULTIFRAME_ERROR] | set_ev[EV_SLTX] | set_ev[EV_SLRX] | set_ev[EV_SLBOTH]))
    else $error("extra event while off");

  chk_invert_first: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_is(cmd_byte, CMD_INVERT_FIRST)) |=> ctrl.invert_first)
    else $error("first channel not inverted");

  chk_invert_second: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_is(cmd_byte, CMD_INVERT_SECOND)) |=> ctrl.invert_second)
    else $error("second channel not inverted");

  chk_polarity_norm: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_is(cmd_byte, CMD_NORMAL_POLARITY)) |=>
      (!ctrl.invert_first && !ctrl.invert_second))
    else $error("polarity not restored");

  chk_pin_select: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && cmd_byte[7:3] == CMD_PIN_REDEFINE_TOP) |=>
      ctrl.pin_sel == $past(cmd_byte[2:0]))
    else $error("pin select wrong");

  // Event gating and answer codes; the lowest pending index is answered first.
  chk_far_code: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && pend[EV_FAR]) |=> status_byte == ST_FAR_END_SIGNAL)
    else $error("far-end code wrong");

  chk_sent_gate: assert property (@(posedge clk_sys) disable iff (srst)
    !ctrl.message_irq |-> !set_ev[EV_SENT])
    else $error("message event while off");

  chk_cont_code: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && next_clr[EV_CONT]) |=> status_byte == ST_CONTENTION_LOST)
    else $error("contention code wrong");

  chk_mf_one_form: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && next_clr[EV_MF1]) |=>
      status_byte == {ST_MF_BUF_ONE_TOP, $past(mf_one_hold)})
    else $error("first buffer report malformed");

  chk_mf_one_gate: assert property (@(posedge clk_sys) disable iff (srst)
    !ctrl.mf_one_irq |-> !set_ev[EV_MF1])
    else $error("first buffer event while off");

  chk_mf_two_gate: assert property (@(posedge clk_sys) disable iff (srst)
    !ctrl.mf_two_irq |-> !set_ev[EV_MF2])
    else $error("second buffer event while off");

  chk_tick_gate: assert property (@(posedge clk_sys) disable iff (srst)
    !(ctrl.tick_every || ctrl.tick_sixth) |-> !set_ev[EV_TICK])
    else $error("tick while both tick modes off");

  chk_rx_multiframe_error_code: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && next_clr[EV_RX_MULTIFRAME_ERROR]) |=> status_byte == ST_RX_MF_ERROR)
    else $error("receive error code wrong");

  chk_slip_single: assert property (@(posedge clk_sys) disable iff (srst)
    set_ev[EV_SLBOTH] |-> !(set_ev[EV_SLTX] || set_ev[EV_SLRX]))
    else $error("slip reported twice");

  chk_slip_code: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && next_clr[EV_SLBOTH]) |=> status_byte == ST_SLIP_BOTH)
    else $error("combined slip code wrong");

  chk_pend_raised: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && link_rise && rose(evt_s.activation_pending, evt_p.activation_pending)) |->
      set_ev[EV_PEND])
    else $error("pending event missed");

  chk_err_raised: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && link_rise && rose(evt_s.frame_loss_error, evt_p.frame_loss_error)) |->
      set_ev[EV_ERR])
    else $error("frame loss event missed");

  chk_done_code: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid && next_clr[EV_DONE]) |=> status_byte == ST_ACTIVATION_DONE)
    else $error("activation done code wrong");

  chk_sent_default: assert property (@(posedge clk_sys)
    srst |=> ctrl.message_irq)
    else $error("message interrupt not on after reset");

  // Pending flags and answer strobe.
  chk_event_kept: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && set_ev[EV_ERR]) |=> pend[EV_ERR])
    else $error("event lost");

  chk_one_clear: assert property (@(posedge clk_sys) disable iff (srst)
    $onehot0(clr_ev))
    else $error("more than one event cleared");

  chk_answer_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && cmd_valid) |=> status_valid)
    else $error("no answer strobe");

  chk_answer_idle: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && !cmd_valid) |=> !status_valid)
    else $error("answer strobe without command");

  chk_irq_level: assert property (@(posedge clk_sys) disable iff (srst)
    ce |=> (irq == (|pend)))
    else $error("interrupt level disagrees with pending flags");
endmodule

// ==== src/iscc_pkg.sv ====
// Purpose: Shared constants and types for the status and control code block.
// Assumes: Byte-wide command and status exchange with the host controller.
// Notes:   Codes are bit patterns of the command and status bytes.
package iscc_pkg;
  localparam logic [7:0] CMD_STATE_REPORT_OFF  = 8'h93;
  localparam logic [7:0] CMD_STATE_REPORT_ON   = 8'h92;
  localparam logic [7:0] CMD_EXTRA_IRQ_ON      = 8'h94;
  localparam logic [7:0] CMD_EXTRA_IRQ_OFF     = 8'h95;
  localparam logic [7:0] CMD_INVERT_FIRST      = 8'h9D;
  localparam logic [7:0] CMD_INVERT_SECOND     = 8'h9E;
  localparam logic [7:0] CMD_NORMAL_POLARITY   = 8'h9F;
  localparam logic [4:0] CMD_PIN_REDEFINE_TOP  = 5'h1C;
  localparam logic [7:0] CMD_MESSAGE_IRQ_ON    = 8'h10;
  localparam logic [7:0] CMD_MESSAGE_IRQ_OFF   = 8'h11;
  localparam logic [7:0] CMD_MF_ONE_IRQ_ON     = 8'h12;
  localparam logic [7:0] CMD_MF_ONE_IRQ_OFF    = 8'h13;
  localparam logic [7:0] CMD_TICK_EVERY_ON     = 8'h22;
  localparam logic [7:0] CMD_TICK_EVERY_OFF    = 8'h23;
  localparam logic [7:0] CMD_TICK_SIXTH_ON     = 8'h24;
  localparam logic [7:0] CMD_TICK_SIXTH_OFF    = 8'h25;
  localparam logic [7:0] CMD_MF_TWO_IRQ_ON     = 8'h26;
  localparam logic [7:0] CMD_MF_TWO_IRQ_OFF    = 8'h27;

  localparam logic [7:0] ST_FAR_END_SIGNAL     = 8'h02;
  localparam logic [7:0] ST_ACTIVATION_PENDING = 8'h03;
  localparam logic [7:0] ST_ACTIVATION_DONE    = 8'h0C;
  localparam logic [7:0] ST_FRAME_LOSS_ERROR   = 8'h0E;
  localparam logic [7:0] ST_DEACTIVATED        = 8'h0F;
  localparam logic [7:0] ST_MESSAGE_SENT       = 8'h06;
  localparam logic [7:0] ST_CONTENTION_LOST    = 8'h07;
  localparam logic [7:0] ST_MF_TX_TICK         = 8'h04;
  localparam logic [7:0] ST_RX_MF_ERROR        = 8'h05;
  localparam logic [7:0] ST_SLIP_TX            = 8'h09;
  localparam logic [7:0] ST_SLIP_RX            = 8'h0A;
  localparam logic [7:0] ST_SLIP_BOTH          = 8'h0B;
  localparam logic [7:0] ST_NO_CHANGE          = 8'h00;
  localparam logic [3:0] ST_MF_BUF_ONE_TOP     = 4'h3;
  localparam logic [3:0] ST_MF_BUF_TWO_TOP     = 4'h5;
  localparam int         STATE_FLAG_BIT        = 7;
  localparam int         TICK_SIXTH_COUNT      = 6;
  localparam int         NUM_EVENTS            = 14;

  // Reset values of the control flags.
  localparam logic RST_STATE_REPORT  = 1'b0;
  localparam logic RST_EXTRA_IRQ     = 1'b0;
  localparam logic RST_INVERT        = 1'b0;
  localparam logic RST_MESSAGE_IRQ   = 1'b1;
  localparam logic RST_MF_IRQ        = 1'b0;
  localparam logic RST_TICK          = 1'b0;
  localparam logic [2:0] RST_PIN_SEL = 3'h0;

  typedef struct packed {
    logic       state_report;
    logic       extra_irq;
    logic       invert_first;
    logic       invert_second;
    logic       message_irq;
    logic       mf_one_irq;
    logic       mf_two_irq;
    logic       tick_every;
    logic       tick_sixth;
    logic [2:0] pin_sel;
  } iscc_ctrl_s;

  typedef struct packed {
    logic       far_end_signal;
    logic       activation_pending;
    logic       activation_done;
    logic       frame_loss_error;
    logic       deactivated_flag;
    logic       message_sent;
    logic       contention_lost;
    logic       mf_rx_buf_one;
    logic       mf_rx_buf_two;
    logic       mf_boundary;
    logic       rx_violation;
    logic       slip_tx;
    logic       slip_rx;
    logic [3:0] mf_one_bits;
    logic [3:0] mf_two_bits;
  } iscc_evt_s;

  typedef enum {EV_FAR, EV_PEND, EV_DONE, EV_ERR, EV_DEACT, EV_SENT, EV_CONT,
                EV_MF1, EV_MF2, EV_TICK, EV_RX_MULTIFRAME_ERROR, EV_SLTX, EV_SLRX, EV_SLBOTH} iscc_ev_e;
endpackage

// ==== src/iscc_link_sync.sv ====
// Purpose: Two-stage synchroniser with edge detection for the link clock.
// Assumes: The link clock is much slower than clk_sys.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module iscc_link_sync
  import iscc_pkg::*;
(
  input  wire logic clk_sys,   // System clock.
  input  wire logic srst,      // Synchronous reset.
  input  wire logic ce,        // Clock enable.
  input  wire logic link_clk,  // Link clock pin.
  output logic      rise       // One-cycle pulse on a rising link edge.
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      rise <= 1'b0;
    end else if (ce) begin
      meta <= link_clk;
      sync <= meta;
      prev <= sync;
      rise <= sync & ~prev;
    end
  end
endmodule

// ==== tb/iscc_host_model.sv ====
// Purpose: Host controller model on the command port.
// Assumes: Commands are driven off the falling edge, one cycle each.
// Notes:   Owes a reply after pending and receive-error reports.
`timescale 1ns/1ps
module iscc_host_model
  import iscc_pkg::*;
#(
  parameter logic [7:0] ACT_REQ = 8'h20, // Activation request byte, plain default.
  parameter logic [3:0] NOTICE  = 4'h1   // Error notice message bits, plain default.
)(
  input  wire logic       clk_sys,      // System clock.
  input  wire logic       srst,         // Synchronous reset.
  input  wire logic [7:0] status_byte,  // Status answer.
  input  wire logic       status_valid, // Answer strobe.
  output logic            cmd_valid,    // Command strobe.
  output logic [7:0]      cmd_byte      // Command byte.
);
  localparam logic [3:0] MF_TX_HIGH_PRIO = 4'h4;
  logic       reply_due;
  logic [7:0] reply;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
  end
  // A reply is owed to the report itself, so any later command settles it.
  always @(posedge clk_sys) begin
    if (srst)
      reply_due <= 1'b0;
    else if (status_valid && status_byte == ST_ACTIVATION_PENDING) begin
      reply_due <= 1'b1;
      reply     <= ACT_REQ;
    end else if (status_valid && status_byte == ST_RX_MF_ERROR) begin
      reply_due <= 1'b1;
      reply     <= {MF_TX_HIGH_PRIO, NOTICE};
    end else if (cmd_valid)
      reply_due <= 1'b0;
  end
  task automatic issue(input logic [7:0] b);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_byte  = b;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_byte  = ~b; // A released byte must not look still valid.
  endtask
  task automatic follow_up();
    if (reply_due)
      issue(reply);
  endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the status and control code block.
// Assumes: Events are held across two link clock periods.
// Notes:   Answers are queued by the driver and compared by a monitor.
`timescale 1ns/1ps
module tb
  import iscc_pkg::*;
;
  logic       clk_sys, srst, ce, link_clk, cmd_valid, status_valid, irq;
  logic [7:0] cmd_byte, status_byte, exp_v;
  logic [2:0] line_state;
  logic [3:0] bits;
  iscc_evt_s  evt;
  iscc_ctrl_s ctrl;
  logic [7:0] expq[$];
  logic [7:0] codes[NUM_EVENTS];
  int         checks, miscompares, dis[6];
  integer     seed;
  localparam logic [7:0] IDLE = 8'hFF;
  localparam logic [7:0] CMDS[17] = '{8'h93, 8'h95, 8'h94, 8'h9D, 8'h9E, 8'h9F, 8'h9D, 8'h11,
    8'h10, 8'h13, 8'h12, 8'h27, 8'h26, 8'h24, 8'h25, 8'h23, 8'h22};
  iscc_top dut_u (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .ce           (ce),
    .link_clk     (link_clk),
    .cmd_valid    (cmd_valid),
    .cmd_byte     (cmd_byte),
    .evt          (evt),
    .line_state   (line_state),
    .status_byte  (status_byte),
    .status_valid (status_valid),
    .irq          (irq),
    .ctrl         (ctrl)
  );
  iscc_host_model host_u (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .status_byte  (status_byte),
    .status_valid (status_valid),
    .cmd_valid    (cmd_valid),
    .cmd_byte     (cmd_byte)
  );
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  function automatic logic [7:0] view(input iscc_ctrl_s c);
    return {c.state_report, c.extra_irq, c.invert_first, c.invert_second, c.message_irq, c.pin_sel};
  endfunction
  function automatic logic [7:0] upd(input logic [7:0] v, input logic [7:0] b);
    case (b)
      CMD_STATE_REPORT_OFF: v[7] = 1'b0;
      CMD_STATE_REPORT_ON:  v[7] = 1'b1;
      CMD_EXTRA_IRQ_ON:     v[6] = 1'b1;
      CMD_EXTRA_IRQ_OFF:    v[6] = 1'b0;
      CMD_INVERT_FIRST:     v[5] = 1'b1;
      CMD_INVERT_SECOND:    v[4] = 1'b1;
      CMD_NORMAL_POLARITY:  v[5:4] = 2'b00;
      CMD_MESSAGE_IRQ_ON:   v[3] = 1'b1;
      CMD_MESSAGE_IRQ_OFF:  v[3] = 1'b0;
      default:              if (b[7:3] == CMD_PIN_REDEFINE_TOP) v[2:0] = b[2:0];
    endcase
    return v;
  endfunction
  // Event bits sit in enum order from the top of the packed struct.
  function automatic iscc_evt_s mk(input int i);
    logic [20:0] v;
    v = {13'h0000, bits, bits};
    if (i == EV_SLBOTH)
      v[9:8] = 2'b11;
    else
      v[20-i] = 1'b1;
    return iscc_evt_s'(v);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    if (status_valid === 1'b1)
      chk(status_byte, expq.size() > 0 ? expq.pop_front() : ~status_byte);
  end
  task automatic send(input logic [7:0] b, input logic [7:0] exp);
    expq.push_back(exp);
    exp_v = upd(exp_v, b);
    host_u.issue(b);
    repeat (2) @(negedge clk_sys);
    chk(view(ctrl), exp_v);
  endtask
  task automatic pulse(input int i);
    @(negedge clk_sys);
    evt = mk(i);
    repeat (16) @(negedge clk_sys);
    evt = '0;
    repeat (16) @(negedge clk_sys);
  endtask
  task automatic ev(input int i, input logic [7:0] exp);
    pulse(i);
    chk({7'h00, irq}, {7'h00, exp != ST_NO_CHANGE});
    send(IDLE, exp);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    seed = 32'hFB2816A5;
    {srst, ce} = 2'b11;
    evt = '0;
    line_state = 3'h0;
    bits = 4'h0;
    dis = '{EV_SLTX, EV_RX_MULTIFRAME_ERROR, EV_SENT, EV_MF1, EV_MF2, EV_TICK};
    codes = '{ST_FAR_END_SIGNAL, ST_ACTIVATION_PENDING, ST_ACTIVATION_DONE, ST_FRAME_LOSS_ERROR,
      ST_DEACTIVATED, ST_MESSAGE_SENT, ST_CONTENTION_LOST, 8'h00, 8'h00, ST_MF_TX_TICK,
      ST_RX_MF_ERROR, ST_SLIP_TX, ST_SLIP_RX, ST_SLIP_BOTH};
    exp_v = {RST_STATE_REPORT, RST_EXTRA_IRQ, RST_INVERT, RST_INVERT, RST_MESSAGE_IRQ, RST_PIN_SEL};
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    chk(view(ctrl), exp_v);
    chk(status_byte, ST_NO_CHANGE);
    send(IDLE, ST_NO_CHANGE);
    done_test("defaults");
    foreach (CMDS[k]) send(CMDS[k], ST_NO_CHANGE);
    send({CMD_PIN_REDEFINE_TOP, 3'($random(seed))}, ST_NO_CHANGE);
    ce = 1'b0;
    host_u.issue(CMD_NORMAL_POLARITY);
    ce = 1'b1;
    chk(view(ctrl), exp_v);
    done_test("control");
    line_state = 3'($random(seed));
    repeat (4) @(negedge clk_sys);
    send(CMD_STATE_REPORT_ON, ST_NO_CHANGE);
    send(IDLE, {1'b1, line_state, 4'h0});
    send(CMD_STATE_REPORT_OFF, {1'b1, line_state, 4'h0});
    send(IDLE, ST_NO_CHANGE);
    done_test("state");
    for (int i = 0; i < NUM_EVENTS; i++) begin
      bits = 4'($random(seed));
      codes[EV_MF1] = {ST_MF_BUF_ONE_TOP, bits};
      codes[EV_MF2] = {ST_MF_BUF_TWO_TOP, bits};
      ev(i, codes[i]);
      if (i == EV_PEND || i == EV_RX_MULTIFRAME_ERROR) begin
        expq.push_back(ST_NO_CHANGE);
        host_u.follow_up();
        repeat (2) @(negedge clk_sys);
      end
    end
    done_test("events");
    foreach (CMDS[k]) if (CMDS[k] inside {8'h95, 8'h11, 8'h13, 8'h27, 8'h23}) send(CMDS[k], 0);
    foreach (dis[k]) ev(dis[k], ST_NO_CHANGE);
    done_test("disabled");
    pulse(EV_FAR);
    pulse(EV_DONE);
    // The lowest pending event index is answered first.
    send(IDLE, ST_FAR_END_SIGNAL);
    send(IDLE, ST_ACTIVATION_DONE);
    send(CMD_TICK_SIXTH_ON, ST_NO_CHANGE);
    repeat (6) pulse(EV_TICK);
    send(IDLE, ST_MF_TX_TICK);
    send(IDLE, ST_NO_CHANGE);
    done_test("pending");
    chk(8'(expq.size()), 8'h00);
    print_verdict();
  end
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule
